/* logic/fbl_pkg.sv */
// package for the host-side block-lock controller of a parallel flash device
// assumes the device follows a command/status protocol on a 16-bit async bus
package fbl_pkg;
	// command codes written on the data bus
	localparam logic [15:0] CMD_LOCK_SETUP    = 16'h0060;
	localparam logic [15:0] CMD_LOCK_CONFIRM  = 16'h0001;
	localparam logic [15:0] CMD_UNLOCK_CONF   = 16'h00D0;
	localparam logic [15:0] CMD_LOCKDOWN_CONF = 16'h002F;
	localparam logic [15:0] CMD_READ_IDENT    = 16'h0090;
	localparam logic [15:0] CMD_READ_ARRAY    = 16'h00FF;
	localparam logic [15:0] CMD_READ_STATUS   = 16'h0070;
	localparam logic [15:0] CMD_CLEAR_STATUS  = 16'h0050;
	localparam logic [15:0] CMD_OTP_SETUP     = 16'h00C0;
	localparam logic [15:0] CMD_SUSPEND       = 16'h00B0;
	localparam logic [15:0] CMD_RESUME        = 16'h00D0;
	// data value that clears the user segment lock bit
	localparam logic [15:0] OTP_USER_LOCK_VAL = 16'hFFFD;
	// offset of block_lock_state inside a block
	localparam logic [21:0] BLOCK_LOCK_STATE_OFS = 22'h000002;
	// block_lock_state field positions
	localparam int BLOCK_LOCKED_BIT   = 0;
	localparam int BLOCK_LOCKDOWN_BIT = 1;
	// status register field positions
	localparam int LOCK_ERROR_STATUS_BIT    = 1;
	localparam int PROGRAM_ERROR_STATUS_BIT = 4;
	localparam int ERASE_ERROR_STATUS_BIT   = 5;
	localparam int READY_STATUS_BIT         = 7;
	// bus cycle timing, in ns and in clock cycles at 100 MHz
	localparam int CLK_PERIOD_NS   = 10;
	localparam int STROBE_NS       = 70;
	localparam int STROBE_CYCLES   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_NS          = 20;
	localparam int GAP_CYCLES      = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// user operation codes
	typedef enum logic [2:0] {
		OP_LOCK     = 3'h0,
		OP_UNLOCK   = 3'h1,
		OP_LOCKDOWN = 3'h2,
		OP_READ_LS  = 3'h3,
		OP_OTP_PROG = 3'h4,
		OP_OTP_READ = 3'h5,
		OP_RAW_CMD  = 3'h6,
		OP_STATUS   = 3'h7
	} fbl_op_t;
endpackage : fbl_pkg

/* logic/fbl_host.sv */
// host-side controller driving a flash device's locking and OTP commands
// assumes async 16-bit flash pins; device sits outside the i_clock domain
//
// Function
// (R1) state is wp level, lockdown, locked bits
// (R2) after reset all blocks read locked
// (R3) locked block program/erase sets lock error
// (R4) lock: 60h then 01h to block
// (R5) unlock: 60h then D0h to block
// (R6) lockdown: 60h then 2Fh to block
// (R7) reset returns every block to locked
// (R8) wp low: lockdown blocks refuse changes
// (R9) wp high: lockdown enforcement disabled
// (R10) wp falling restores lockdown blocks
// (R11) 90h then read base+2 gives lock bits
// (R12) no command clears the lockdown bit
// (R13) locking allowed during erase suspend
// (R14) no locking during program suspend
// (R15) bad confirm sets program and erase errors
// (R16) lock error persists through resumed erase
// (R17) protection register 128 bits, two halves
// (R18) OTP read in ident mode, exit FFh
// (R19) OTP program: C0h then address/data
// (R20) locked OTP program sets program+lock errors
// (R21) user OTP locked by writing FFFDh
// (R22) locked OTP segment never changes again
// (R23) locked-block hit aborts, status mode
// (R24) status bit 7 one means ready
// (R25) confirm address selects target block
`timescale 1ns/1ps
`default_nettype none
module fbl_host (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	// user request
	input  wire logic        i_req_valid,
	output logic             o_req_ready,
	input  wire logic [2:0]  i_req_op,
	input  wire logic [21:0] i_req_addr,
	input  wire logic [15:0] i_req_data,
	input  wire logic        i_prog_suspended,
	// user answer
	output logic             o_rsp_valid,
	output logic [15:0]      o_rsp_data,
	output logic             o_rsp_locked,
	output logic             o_rsp_lockdown,
	output logic             o_rsp_refused,
	// flash pins
	output logic [21:0]      o_flash_addr,
	input  wire logic [15:0] i_flash_dq,
	output logic [15:0]      o_flash_dq,
	output logic             o_flash_dq_oe,
	output logic             o_flash_ce_n,
	output logic             o_flash_oe_n,
	output logic             o_flash_we_n
);
	//////////////////////////////////////////////////////////////////////////////
	// states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_WSTB  = 6'b000010,
		ST_WGAP  = 6'b000100,
		ST_RSTB  = 6'b001000,
		ST_RGAP  = 6'b010000,
		ST_DONE  = 6'b100000
	} fbl_state_t;

	// whole module state
	typedef struct packed {
		fbl_state_t  st;
		logic [2:0]  op;
		logic [1:0]  step;     // which bus cycle of the sequence
		logic [3:0]  cnt;      // strobe/gap timer
		logic [21:0] addr;
		logic [15:0] data;
		logic [21:0] pin_addr;
		logic [15:0] pin_dq;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [15:0] rsp;
		logic        rsp_v;
		logic        refused;
		logic [15:0] sync1;    // first synchroniser stage
		logic [15:0] sync2;
	} fbl_regs_t;

	fbl_regs_t r;
	fbl_regs_t next_r;

	//////////////////////////////////////////////////////////////////////////////
	// index of the last bus cycle in each operation, last cycle always a read or a write
	function automatic logic [1:0] last_step(input logic [2:0] op);
		case (op)
			fbl_pkg::OP_LOCK, fbl_pkg::OP_UNLOCK, fbl_pkg::OP_LOCKDOWN: last_step = 2'h1;
			fbl_pkg::OP_READ_LS, fbl_pkg::OP_OTP_READ:                  last_step = 2'h2;
			fbl_pkg::OP_OTP_PROG:                                       last_step = 2'h2;
			fbl_pkg::OP_RAW_CMD:                                        last_step = 2'h0; // one write only
			default:                                                    last_step = 2'h1;
		endcase
	endfunction : last_step

	// is the given step a read cycle
	function automatic logic is_read(input logic [2:0] op, input logic [1:0] step);
		case (op)
			fbl_pkg::OP_READ_LS, fbl_pkg::OP_OTP_READ: is_read = (step == 2'h1);
			fbl_pkg::OP_OTP_PROG, fbl_pkg::OP_STATUS:  is_read = (step == last_step(op) - 2'h1) ? 1'b0 :
			                                                      (step == last_step(op));
			default:                                   is_read = 1'b0;
		endcase
	endfunction : is_read

	//////////////////////////////////////////////////////////////////////////////
	// address and data driven on each step
	logic [21:0] cyc_addr;
	logic [15:0] cyc_data;
	always_comb begin
		cyc_addr = r.addr;   // confirm address picks the block, see (R25)
		cyc_data = fbl_pkg::CMD_READ_ARRAY;
		case (r.op)
			fbl_pkg::OP_LOCK: begin
				cyc_data = (r.step == 2'h0) ? fbl_pkg::CMD_LOCK_SETUP : fbl_pkg::CMD_LOCK_CONFIRM; // see (R4)
			end
			fbl_pkg::OP_UNLOCK: begin
				cyc_data = (r.step == 2'h0) ? fbl_pkg::CMD_LOCK_SETUP : fbl_pkg::CMD_UNLOCK_CONF; // see (R5)
			end
			fbl_pkg::OP_LOCKDOWN: begin
				cyc_data = (r.step == 2'h0) ? fbl_pkg::CMD_LOCK_SETUP : fbl_pkg::CMD_LOCKDOWN_CONF; // see (R6)
			end
			fbl_pkg::OP_READ_LS: begin
				// ident mode, read block base + 2, then back to array, see (R11)
				cyc_data = (r.step == 2'h0) ? fbl_pkg::CMD_READ_IDENT : fbl_pkg::CMD_READ_ARRAY;
				if (r.step == 2'h1) begin
					cyc_addr = r.addr + fbl_pkg::BLOCK_LOCK_STATE_OFS;
				end
			end
			fbl_pkg::OP_OTP_READ: begin
				// ident mode read, exit with read array, see (R18)
				cyc_data = (r.step == 2'h0) ? fbl_pkg::CMD_READ_IDENT : fbl_pkg::CMD_READ_ARRAY;
			end
			fbl_pkg::OP_OTP_PROG: begin
				// setup then latched address/data, status read last, see (R19) (R21)
				cyc_data = (r.step == 2'h0) ? fbl_pkg::CMD_OTP_SETUP : r.data;
			end
			fbl_pkg::OP_STATUS: begin
				cyc_data = fbl_pkg::CMD_READ_STATUS;
			end
			default: begin
				cyc_data = r.data;   // raw command, e.g. suspend/resume/clear
			end
		endcase
	end

	// lock commands are refused while a program is suspended, see (R14)
	logic lock_op;
	assign lock_op = (i_req_op == fbl_pkg::OP_LOCK) || (i_req_op == fbl_pkg::OP_UNLOCK) ||
	                 (i_req_op == fbl_pkg::OP_LOCKDOWN);

	//////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_r       = r;
		next_r.rsp_v = 1'b0;
		next_r.sync1 = i_flash_dq;
		next_r.sync2 = r.sync1;
		case (r.st)
			ST_IDLE: begin
				if (i_req_valid) begin
					next_r.op      = i_req_op;
					next_r.addr    = i_req_addr;
					next_r.data    = i_req_data;
					next_r.step    = 2'h0;
					next_r.refused = lock_op && i_prog_suspended;  // see (R14)
					next_r.st      = (lock_op && i_prog_suspended) ? ST_DONE : ST_WSTB;
					next_r.cnt     = 4'(fbl_pkg::STROBE_CYCLES);
				end
			end
			ST_WSTB, ST_RSTB: begin
				// hold the strobe low for the access time
				next_r.ce_n     = 1'b0;
				next_r.pin_addr = cyc_addr;
				next_r.pin_dq   = cyc_data;
				next_r.dq_oe    = (r.st == ST_WSTB);
				next_r.we_n     = (r.st != ST_WSTB);
				next_r.oe_n     = (r.st == ST_WSTB);
				if (r.cnt == 4'h0) begin
					next_r.st   = (r.st == ST_WSTB) ? ST_WGAP : ST_RGAP;
					next_r.ce_n = 1'b1;
					next_r.we_n = 1'b1;
					next_r.oe_n = 1'b1;
					next_r.cnt  = 4'(fbl_pkg::GAP_CYCLES + 2);  // gap also covers the synchroniser
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			ST_WGAP, ST_RGAP: begin
				next_r.dq_oe = 1'b0;
				// first gap cycle: sync2 still holds a value taken inside the strobe,
				// two cycles later it would show the released bus
				if (r.st == ST_RGAP && r.cnt == 4'(fbl_pkg::GAP_CYCLES + 2)) begin
					next_r.rsp = r.sync2;    // sampled after two flip-flops
				end
				if (r.cnt == 4'h0) begin
					next_r.cnt = 4'(fbl_pkg::STROBE_CYCLES);
					if (r.step == last_step(r.op)) begin
						next_r.st = ST_DONE;
					end else begin
						next_r.step = r.step + 2'h1;
						// a read step gets its own strobe state, never a stray write pulse
						next_r.st   = is_read(r.op, r.step + 2'h1) ? ST_RSTB : ST_WSTB;
					end
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			ST_DONE: begin
				next_r.rsp_v = 1'b1;
				next_r.st    = ST_IDLE;
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// single state register, frozen while clock enable is low
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			r          <= '0;
			r.st       <= ST_IDLE;
			r.ce_n     <= 1'b1;
			r.oe_n     <= 1'b1;
			r.we_n     <= 1'b1;
		end else if (i_clk_en) begin
			r <= next_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_req_ready    = (r.st == ST_IDLE);
	assign o_rsp_valid    = r.rsp_v;
	assign o_rsp_data     = r.rsp;
	assign o_rsp_locked   = r.rsp[fbl_pkg::BLOCK_LOCKED_BIT];    // see (R1) (R11)
	assign o_rsp_lockdown = r.rsp[fbl_pkg::BLOCK_LOCKDOWN_BIT];
	assign o_rsp_refused  = r.refused;
	assign o_flash_addr   = r.pin_addr;
	assign o_flash_dq     = r.pin_dq;
	assign o_flash_dq_oe  = r.dq_oe;
	assign o_flash_ce_n   = r.ce_n;
	assign o_flash_oe_n   = r.oe_n;
	assign o_flash_we_n   = r.we_n;
endmodule : fbl_host
`default_nettype wire

/* testbench/fbl_host_properties.sv */
// checker for the flash lock host: pin strobes and user handshake
// assumes it is bound to fbl_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fbl_host_chk (
	// clock, reset and user side
	input wire logic        i_clock,
	input wire logic        i_sys_rst,
	input wire logic        i_clk_en,
	input wire logic        i_req_valid,
	input wire logic        o_req_ready,
	input wire logic [2:0]  i_req_op,
	input wire logic        i_prog_suspended,
	input wire logic        o_rsp_valid,
	input wire logic        o_rsp_refused,
	// flash pins
	input wire logic [15:0] o_flash_dq,
	input wire logic        o_flash_dq_oe,
	input wire logic        o_flash_ce_n,
	input wire logic        o_flash_oe_n,
	input wire logic        o_flash_we_n
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// request taken at this edge
	wire logic tk    = i_req_valid && o_req_ready && i_clk_en;
	// lock ops split by the suspend level, refused ones must stay off the pins
	wire logic tk_lk = tk && i_req_op <= 3'h2 && !i_prog_suspended;
	wire logic tk_rf = tk && i_req_op <= 3'h2 && i_prog_suspended;
	////////////////////////////////
	refuse_answer_a: assert property (tk_rf |-> ##2 (o_rsp_valid && o_rsp_refused))
		else $error("refused lock op not answered");
	refuse_quiet_a: assert property (tk_rf |=> o_flash_ce_n [*3])
		else $error("pins moved on refused lock op");
	write_drive_a: assert property (!o_flash_we_n |-> o_flash_dq_oe && !o_flash_ce_n && o_flash_oe_n)
		else $error("write strobe without data drive");
	read_release_a: assert property (!o_flash_oe_n |-> !o_flash_dq_oe && o_flash_we_n)
		else $error("read while driving the bus");
	lock_setup_a: assert property (tk_lk |-> ##2 (!o_flash_we_n && o_flash_dq == fbl_pkg::CMD_LOCK_SETUP))
		else $error("lock op without setup code");
	lock_conf_a: assert property (tk_lk && i_req_op == 3'h0 |-> ##[10:20] (!o_flash_we_n && o_flash_dq == 16'h0001))
		else $error("lock confirm missing");
	unlock_conf_a: assert property (tk_lk && i_req_op == 3'h1 |-> ##[10:20] (!o_flash_we_n && o_flash_dq == 16'h00D0))
		else $error("unlock confirm missing");
	down_conf_a: assert property (tk_lk && i_req_op == 3'h2 |-> ##[10:20] (!o_flash_we_n && o_flash_dq == 16'h002F))
		else $error("lockdown confirm missing");
	ident_cmd_a: assert property (tk && i_req_op == 3'h3 |-> ##2 (!o_flash_we_n && o_flash_dq == 16'h0090))
		else $error("lock state read without identifier code");
	otp_setup_a: assert property (tk && i_req_op == 3'h4 |-> ##2 (!o_flash_we_n && o_flash_dq == 16'h00C0))
		else $error("protection program without setup code");
	// main scenarios reached
	cover property (tk_lk);
	cover property (tk_rf);
	cover property (tk && i_req_op == 3'h4);
endmodule : fbl_host_chk
bind fbl_host fbl_host_chk u_chk (.i_clock, .i_sys_rst, .i_clk_en, .i_req_valid, .o_req_ready, .i_req_op,
	.i_prog_suspended, .o_rsp_valid, .o_rsp_refused, .o_flash_dq, .o_flash_dq_oe, .o_flash_ce_n,
	.o_flash_oe_n, .o_flash_we_n);
`default_nettype wire

/* testbench/fbl_flash_model.sv */
// behavioural flash device: block lock bits, status and protection words
// assumes the host holds address and data steady through each write strobe
`timescale 1ns/1ps
`default_nettype none
module fbl_flash_model (
	// pins from the host
	input  wire logic [21:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_wp,
	// read data to the host
	output logic      [15:0] o_dq
);
	logic [7:0]  lk   = 8'hFF;    // all locked at power-up
	logic [7:0]  ld   = 8'h00;    // lockdown only cleared by power-up
	logic [15:0] sr   = 16'h0080; // ready
	logic [15:0] otp [16];        // word 0 is the lock word
	logic [1:0]  md   = 2'h0;     // 0 array, 1 status, 2 identifier
	logic        lset = 1'b0;
	logic        oset = 1'b0;
	logic        pset = 1'b0;     // word program set up
	logic [15:0] rd;
	wire logic [2:0] b = i_addr[18:16]; // any word of a block selects it
	initial begin
		foreach (otp[i]) otp[i] = 16'hFFFF;
		otp[0] = 16'hFFFE; // factory half already locked
	end
	////////////////////////////////
	// commands take effect on the rising write strobe
	always @(posedge i_we_n) begin
		if (lset) begin
			lset = 1'b0;
			md = 2'h1;
			case (i_dq)
				16'h0001: lk[b] = 1'b1;
				16'h00D0: if (i_wp || !ld[b]) lk[b] = 1'b0;
				16'h002F: {ld[b], lk[b]} = 2'b11;
				default: sr[5:4] = 2'b11; // sticky until cleared
			endcase
		end else if (oset) begin
			oset = 1'b0;
			md = 2'h1;
			if (!otp[0][1]) sr = sr | 16'h0012;
			else otp[i_addr[3:0]] = otp[i_addr[3:0]] & i_dq;
		end else if (pset) begin
			pset = 1'b0;
			md = 2'h1;
			if (lk[b]) sr[1] = 1'b1; // locked block aborts, status mode
		end else case (i_dq)
			16'h0040: pset = 1'b1;
			16'h0060: lset = 1'b1;
			16'h00C0: oset = 1'b1;
			16'h0090: md = 2'h2;
			16'h0070: md = 2'h1;
			16'h0050: sr = 16'h0080;
			default: md = 2'h0;
		endcase
	end
	// pin going low restores lockdown blocks
	always @(negedge i_wp) lk = lk | ld;
	// lock state at block offset 2, protection words low in the space
	always_comb begin
		if (md == 2'h1) rd = sr;
		else if (md == 2'h0) rd = 16'hFFFF;
		else if (i_addr[15:0] == 16'h0002) rd = {14'h0, ld[b], lk[b]};
		else rd = otp[i_addr[3:0]];
	end
	// released bus shows the inverse so stale data cannot pass
	assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
endmodule : fbl_flash_model
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench: lock ops, lock state reads, errors, protection words
// assumes fbl_host in front of the behavioural flash model
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic        valid = 1'b0;
	logic        susp  = 1'b0;
	logic        wp    = 1'b0;
	logic        cen   = 1'b1;
	logic [2:0]  op    = 3'h0;
	logic [21:0] addr  = 22'h0;
	logic [15:0] data  = 16'h0;
	logic [15:0] rdata, fin, fout;
	logic [21:0] faddr;
	logic        ready, rvalid, refused, lkd, lkdn, dq_oe, ce_n, oe_n, we_n;
	int          fail_count = 0;
	int          tests_run  = 0;
	initial forever #5 clk = ~clk;
	fbl_host i_dut (.i_clock(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_req_valid(valid), .o_req_ready(ready),
		.i_req_op(op), .i_req_addr(addr), .i_req_data(data), .i_prog_suspended(susp), .o_rsp_valid(rvalid),
		.o_rsp_data(rdata), .o_rsp_locked(lkd), .o_rsp_lockdown(lkdn), .o_rsp_refused(refused),
		.o_flash_addr(faddr), .i_flash_dq(fin), .o_flash_dq(fout), .o_flash_dq_oe(dq_oe),
		.o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n));
	fbl_flash_model i_dev (.i_addr(faddr), .i_dq(fout), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_wp(wp), .o_dq(fin));
	////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one request, held for the taking edge, then a bounded wait for the answer
	task automatic req(input logic [2:0] o, input logic [21:0] a, input logic [15:0] d);
		int n;
		n = 0;
		op = o;
		addr = a;
		data = d;
		valid = 1'b1;
		@(negedge clk);
		valid = 1'b0;
		while (rvalid !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n == 100) begin
			fail_count++;
			$display("[ERR] %0t no answer", $time);
		end
		@(negedge clk);
	endtask : req
	task automatic ls(input logic [21:0] a, input logic [1:0] e);
		req(3'h3, a, 16'h0);
		check({14'h0, lkdn, lkd}, {14'h0, e});
	endtask : ls
	task automatic results();
		if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	////////////////////////////////
	// main sequence, inputs move on falling edges only
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		ls(22'h000000, 2'b01);
		req(3'h1, 22'h010123, 16'h0);
		ls(22'h010000, 2'b00);
		req(3'h0, 22'h01FFFF, 16'h0);
		ls(22'h010000, 2'b01);
		req(3'h2, 22'h020000, 16'h0);
		req(3'h1, 22'h020000, 16'h0);
		ls(22'h020000, 2'b11);
		wp = 1'b1;
		req(3'h1, 22'h020000, 16'h0);
		ls(22'h020000, 2'b10);
		wp = 1'b0;
		// freeze the controller a few cycles inside the read, the answer must not change
		fork
			ls(22'h020000, 2'b11);
			begin
				repeat (5) @(negedge clk);
				cen = 1'b0;
				repeat (4) @(negedge clk);
				cen = 1'b1;
			end
		join
		susp = 1'b1;
		req(3'h1, 22'h000000, 16'h0);
		check({15'h0, refused}, 16'h0001);
		susp = 1'b0;
		ls(22'h000000, 2'b01);
		req(3'h6, 22'h000010, 16'h0040);
		req(3'h6, 22'h000010, 16'h5A5A);
		req(3'h7, 22'h000010, 16'h0);
		check(rdata, 16'h0082);
		req(3'h6, 22'h000000, 16'h0050);
		req(3'h6, 22'h000000, 16'h0060);
		req(3'h6, 22'h000000, 16'h0033);
		req(3'h7, 22'h000000, 16'h0);
		check(rdata, 16'h00B0);
		req(3'h6, 22'h000000, 16'h0050);
		req(3'h4, 22'h000081, 16'h1234);
		check(rdata, 16'h0080);
		req(3'h5, 22'h000081, 16'h0);
		check(rdata, 16'h1234);
		req(3'h4, 22'h000080, fbl_pkg::OTP_USER_LOCK_VAL);
		req(3'h4, 22'h000081, 16'h0000);
		check(rdata, 16'h0092);
		req(3'h5, 22'h000081, 16'h0);
		check(rdata, 16'h1234);
		results();
	end
	// 26 ops of under 50 cycles each, so 30 us is ample
	initial begin
		#30000;
		fail_count++;
		results();
	end
endmodule : tb
`default_nettype wire
